// >>> core/csi2_rx_defs.svh
// Constant values for the camera serial lane receive front end.
// Assumes inclusion by bare name from any core file that needs it.
`ifndef CSI2_RX_DEFS_SVH
`define CSI2_RX_DEFS_SVH

// ----------------------------------------------------------------
// Low-power line states as {p, n}
// ----------------------------------------------------------------
`define LP_STOP        2'b11
`define LP_HS_RQST     2'b01
`define LP_BRIDGE      2'b00

// ----------------------------------------------------------------
// Lane and packet layer constants
// ----------------------------------------------------------------
`define NUM_DLANES     4
`define CLK_LANE       4
`define HS_SYNC_BYTE   8'hb8
`define SHORT_DT_MAX   6'h0f
`define DT_FRAME_START 6'h00
`define DT_FRAME_END   6'h01
`define HDR_BYTES      2'h3
`define CRC_INIT       16'hffff
`define CRC_POLY       16'h8408
`define FIFO_WIDTH     9
`define FIFO_DEPTH     8

`endif

// >>> core/csi2_rx_pkg.sv
// Types shared by the lane receive front end files.
// Assumes nothing beyond a SystemVerilog compiler.
package csi2_rx_pkg;

  // Per-lane sequencing state
  typedef enum logic [2:0] {
    LS_IDLE,
    LS_STOP,
    LS_RQST,
    LS_HS
  } lane_st_t;

  // Packet parser state
  typedef enum logic [2:0] {
    PS_HDR,
    PS_PAY,
    PS_FTR,
    PS_SKIP
  } pkt_st_t;

endpackage

// >>> core/csi2_byte_fifo.sv
// Small synchronous FIFO with a registered output stage.
// Assumes one clock, synchronous active-high reset and a clock enable.
`timescale 1ns/1ps
`default_nettype none

module csi2_byte_fifo #(
  parameter int W = 9,
  parameter int D = 8
) (
  // Clock and reset
  input  wire logic         mclk,
  input  wire logic         srst,
  input  wire logic         ce,
  // Fill side
  input  wire logic         in_valid,
  input  wire logic [W-1:0] in_data,
  output logic              in_ready,
  // Drain side
  output logic              out_valid,
  output logic [W-1:0]      out_data,
  input  wire logic         out_ready
);

  localparam int AW = (D > 1) ? $clog2(D) : 1;
  localparam int CW = $clog2(D + 1);

  logic [W-1:0]  mem_ff [D];
  logic [AW-1:0] wr_ptr_ff, nxt_wr_ptr;
  logic [AW-1:0] rd_ptr_ff, nxt_rd_ptr;
  logic [CW-1:0] cnt_ff, nxt_cnt;
  logic          oval_ff, nxt_oval;
  logic [W-1:0]  odat_ff, nxt_odat;
  logic          push;
  logic          pop;

  function automatic logic [AW-1:0] ptr_inc(input logic [AW-1:0] p);
    ptr_inc = (p == AW'(D - 1)) ? '0 : AW'(p + 1'b1);
  endfunction

  assign in_ready  = (cnt_ff != CW'(D));
  assign out_valid = oval_ff;
  assign out_data  = odat_ff;

  always_comb begin
    push       = in_valid && in_ready;
    pop        = (cnt_ff != '0) && (!oval_ff || out_ready);
    nxt_wr_ptr = push ? ptr_inc(wr_ptr_ff) : wr_ptr_ff;
    nxt_rd_ptr = pop ? ptr_inc(rd_ptr_ff) : rd_ptr_ff;
    nxt_cnt    = CW'(cnt_ff + CW'(push) - CW'(pop));
    nxt_oval   = pop ? 1'b1 : (out_ready ? 1'b0 : oval_ff);
    nxt_odat   = pop ? mem_ff[rd_ptr_ff] : odat_ff;
  end

  always_ff @(posedge mclk) begin
    if (srst) begin
      wr_ptr_ff <= '0;
      rd_ptr_ff <= '0;
      cnt_ff    <= '0;
      oval_ff   <= 1'b0;
      odat_ff   <= '0;
    end else if (ce) begin
      wr_ptr_ff <= nxt_wr_ptr;
      rd_ptr_ff <= nxt_rd_ptr;
      cnt_ff    <= nxt_cnt;
      oval_ff   <= nxt_oval;
      odat_ff   <= nxt_odat;
    end
  end

  // Storage needs no reset; only words behind the count are ever read
  always_ff @(posedge mclk) begin
    if (ce && push) begin
      mem_ff[wr_ptr_ff] <= in_data;
    end
  end

endmodule

`default_nettype wire

// >>> core/csi2_rx_front_end.sv
// Lane sequencing, byte recovery, lane merge and packet parsing for a
// camera serial link receiver. Assumes all lane pins are asynchronous to
// mclk and that the lane clock is slow enough to be oversampled by mclk.
`timescale 1ns/1ps
`default_nettype none

`include "csi2_rx_defs.svh"

module csi2_rx_front_end
  import csi2_rx_pkg::*;
(
  // Clock, reset, enable
  input  wire logic       mclk,
  input  wire logic       srst,
  input  wire logic       ce,
  // Configuration
  input  wire logic       cfg_cont_clk,
  input  wire logic [1:0] cfg_lanes,
  input  wire logic       err_clr,
  // Lane pins
  input  wire logic       clk_lp_p,
  input  wire logic       clk_lp_n,
  input  wire logic       clk_hs,
  input  wire logic [3:0] dat_lp_p,
  input  wire logic [3:0] dat_lp_n,
  input  wire logic [3:0] dat_hs,
  // Termination enables
  output logic            clk_term_en,
  output logic [3:0]      dat_term_en,
  // Short packets
  output logic            short_valid,
  output logic [7:0]      short_id,
  output logic [15:0]     short_data,
  output logic            in_frame,
  // Payload stream
  output logic            pix_valid,
  output logic [7:0]      pix_data,
  output logic            pix_last,
  input  wire logic       pix_ready,
  // Status
  output logic            ecc_corr,
  output logic            ecc_err,
  output logic            crc_err,
  output logic            ovf_err
);

  // ----------------------------------------------------------------
  // Functions
  // ----------------------------------------------------------------
  function automatic logic [3:0] lane_mask(input logic [1:0] cfg);
    case (cfg)
      2'h1:    lane_mask = 4'h3;
      2'h2:    lane_mask = 4'hf;
      default: lane_mask = 4'h1;
    endcase
  endfunction

  // Stop state is the only way out of high speed; LP-10 escape entry
  // just falls back to waiting for a stop state
  function automatic lane_st_t lane_next(input lane_st_t st, input logic [1:0] lp);
    case (st)
      LS_IDLE: lane_next = (lp == `LP_STOP) ? LS_STOP : LS_IDLE;
      LS_STOP: begin
        if (lp == `LP_STOP) lane_next = LS_STOP;
        else if (lp == `LP_HS_RQST) lane_next = LS_RQST;
        else lane_next = LS_IDLE;
      end
      LS_RQST: begin
        if (lp == `LP_BRIDGE) lane_next = LS_HS;
        else if (lp == `LP_HS_RQST) lane_next = LS_RQST;
        else if (lp == `LP_STOP) lane_next = LS_STOP;
        else lane_next = LS_IDLE;
      end
      LS_HS:   lane_next = (lp == `LP_STOP) ? LS_STOP : LS_HS;
      default: lane_next = LS_IDLE;
    endcase
  endfunction

  function automatic logic [5:0] ecc_col(input int i);
    case (i)
      0: ecc_col = 6'h07;   1: ecc_col = 6'h0b;   2: ecc_col = 6'h0d;
      3: ecc_col = 6'h0e;   4: ecc_col = 6'h13;   5: ecc_col = 6'h15;
      6: ecc_col = 6'h16;   7: ecc_col = 6'h19;   8: ecc_col = 6'h1a;
      9: ecc_col = 6'h1c;   10: ecc_col = 6'h23;  11: ecc_col = 6'h25;
      12: ecc_col = 6'h26;  13: ecc_col = 6'h29;  14: ecc_col = 6'h2a;
      15: ecc_col = 6'h2c;  16: ecc_col = 6'h31;  17: ecc_col = 6'h32;
      18: ecc_col = 6'h34;  19: ecc_col = 6'h38;  20: ecc_col = 6'h1f;
      21: ecc_col = 6'h2f;  22: ecc_col = 6'h37;  23: ecc_col = 6'h3b;
      default: ecc_col = 6'h00;
    endcase
  endfunction

  // Returns {two_bit_error, corrected, fixed_header}
  function automatic logic [25:0] ecc_fix(input logic [23:0] h, input logic [5:0] code);
    logic [5:0]  syn;
    logic [23:0] fixed;
    logic        hit;
    syn   = code;
    fixed = h;
    hit   = 1'b0;
    for (int i = 0; i < 24; i++) begin
      if (h[i]) syn = syn ^ ecc_col(i);
    end
    for (int i = 0; i < 24; i++) begin
      if (syn != 6'h00 && ecc_col(i) == syn) begin
        fixed[i] = ~h[i];
        hit      = 1'b1;
      end
    end
    if (syn == 6'h00) ecc_fix = {2'b00, fixed};
    else if (hit || ((syn & (syn - 6'h01)) == 6'h00)) ecc_fix = {2'b01, fixed};
    else ecc_fix = {2'b10, h};
  endfunction

  // Reflected CCITT polynomial, least significant bit first
  function automatic logic [15:0] crc_byte(input logic [15:0] c, input logic [7:0] d);
    logic [15:0] r;
    r = c;
    for (int i = 0; i < 8; i++) begin
      r = (r[0] ^ d[i]) ? ((r >> 1) ^ `CRC_POLY) : (r >> 1);
    end
    crc_byte = r;
  endfunction

  // ----------------------------------------------------------------
  // Pin synchronisers
  // ----------------------------------------------------------------
  // Every lane pin is only sampled; nothing here drives back
  logic [9:0] lp_s1_ff, lp_s2_ff, nxt_lp_s1;
  logic [4:0] hs_s1_ff, hs_s2_ff, nxt_hs_s1;
  logic       clk_d_ff;

  always_comb begin
    for (int l = 0; l < `NUM_DLANES; l++) begin
      nxt_lp_s1[2*l+1 -: 2] = {dat_lp_p[l], dat_lp_n[l]};
    end
    nxt_lp_s1[9:8] = {clk_lp_p, clk_lp_n};
    nxt_hs_s1      = {clk_hs, dat_hs};
  end

  always_ff @(posedge mclk) begin
    if (srst) begin
      lp_s1_ff <= 10'h3ff;
      lp_s2_ff <= 10'h3ff;
      hs_s1_ff <= 5'h00;
      hs_s2_ff <= 5'h00;
      clk_d_ff <= 1'b0;
    end else if (ce) begin
      lp_s1_ff <= nxt_lp_s1;
      lp_s2_ff <= lp_s1_ff;
      hs_s1_ff <= nxt_hs_s1;
      hs_s2_ff <= hs_s1_ff;
      clk_d_ff <= hs_s2_ff[`CLK_LANE];
    end
  end

  // ----------------------------------------------------------------
  // Lane sequencing and termination
  // ----------------------------------------------------------------
  lane_st_t   lst_ff [5];
  lane_st_t   nxt_lst [5];
  logic [4:0] term_ff, nxt_term;
  logic [3:0] mask;

  always_comb begin
    mask = lane_mask(cfg_lanes);
    for (int l = 0; l < 5; l++) begin
      nxt_lst[l] = lane_next(lst_ff[l], lp_s2_ff[2*l+1 -: 2]);
      if (l < `NUM_DLANES && !mask[2'(l)]) nxt_lst[l] = LS_IDLE;
      if (l == `CLK_LANE && cfg_cont_clk) nxt_lst[l] = LS_HS;
      nxt_term[l] = (nxt_lst[l] == LS_HS);
    end
  end

  always_ff @(posedge mclk) begin
    if (srst) begin
      for (int l = 0; l < 5; l++) lst_ff[l] <= LS_IDLE;
      term_ff <= 5'h00;
    end else if (ce) begin
      for (int l = 0; l < 5; l++) lst_ff[l] <= nxt_lst[l];
      term_ff <= nxt_term;
    end
  end

  assign clk_term_en = term_ff[`CLK_LANE];
  assign dat_term_en = term_ff[3:0];

  // ----------------------------------------------------------------
  // Byte recovery and lane merge
  // ----------------------------------------------------------------
  // Bits are taken on both lane clock edges; a lane locks its byte
  // boundary on the sync byte, which absorbs lane-to-lane bit skew
  logic [7:0] sh_ff [4];
  logic [7:0] nxt_sh [4];
  logic [7:0] lbyte_ff [4];
  logic [7:0] nxt_lbyte [4];
  logic [2:0] bcnt_ff [4];
  logic [2:0] nxt_bcnt [4];
  logic [3:0] algn_ff, nxt_algn, have_ff, nxt_have;
  logic       mrg_ff, nxt_mrg;
  logic [1:0] midx_ff, nxt_midx;
  logic       ovf_ff, nxt_ovf;
  logic       edge_seen;
  logic       burst_on;
  logic       mb_valid;
  logic [7:0] mb_data;
  logic       pkt_ready;
  logic [7:0] shn;
  logic [1:0] last_idx;

  always_comb begin
    edge_seen = (hs_s2_ff[`CLK_LANE] != clk_d_ff) && (lst_ff[`CLK_LANE] == LS_HS);
    burst_on  = (lst_ff[0] == LS_HS);
    last_idx  = (mask == 4'hf) ? 2'h3 : ((mask == 4'h3) ? 2'h1 : 2'h0);
    nxt_have  = have_ff;
    nxt_mrg   = mrg_ff;
    nxt_midx  = midx_ff;
    nxt_ovf   = err_clr ? 1'b0 : ovf_ff;
    mb_valid  = mrg_ff;
    mb_data   = lbyte_ff[midx_ff];
    shn       = 8'h00;
    if (mrg_ff && pkt_ready) begin
      nxt_have[midx_ff] = 1'b0;
      nxt_midx          = 2'(midx_ff + 2'h1);
      if (midx_ff == last_idx) begin
        nxt_mrg  = 1'b0;
        nxt_midx = 2'h0;
      end
    end else if (!mrg_ff && ((have_ff & mask) == mask)) begin
      nxt_mrg  = 1'b1;
      nxt_midx = 2'h0;
    end
    for (int l = 0; l < `NUM_DLANES; l++) begin
      nxt_sh[l]    = sh_ff[l];
      nxt_lbyte[l] = lbyte_ff[l];
      nxt_bcnt[l]  = bcnt_ff[l];
      nxt_algn[l]  = algn_ff[l];
      if (lst_ff[l] != LS_HS) begin
        nxt_sh[l]   = 8'h00;
        nxt_bcnt[l] = 3'h0;
        nxt_algn[l] = 1'b0;
      end else if (edge_seen) begin
        shn       = {hs_s2_ff[l], sh_ff[l][7:1]};
        nxt_sh[l] = shn;
        if (!algn_ff[l]) begin
          nxt_algn[l] = (shn == `HS_SYNC_BYTE);
          nxt_bcnt[l] = 3'h0;
        end else begin
          nxt_bcnt[l] = 3'(bcnt_ff[l] + 3'h1);
          if (bcnt_ff[l] == 3'h7) begin
            nxt_lbyte[l] = shn;
            if (have_ff[l]) nxt_ovf = 1'b1;
            nxt_have[l] = 1'b1; // A fresh byte wins over the merge clear
          end
        end
      end
    end
    // Bytes left over when the burst ends are not a whole word group
    if (!burst_on) begin
      nxt_have = 4'h0;
      nxt_mrg  = 1'b0;
      nxt_midx = 2'h0;
    end
  end

  always_ff @(posedge mclk) begin
    if (srst) begin
      for (int l = 0; l < `NUM_DLANES; l++) begin
        sh_ff[l]    <= 8'h00;
        lbyte_ff[l] <= 8'h00;
        bcnt_ff[l]  <= 3'h0;
      end
      algn_ff <= 4'h0;
      have_ff <= 4'h0;
      mrg_ff  <= 1'b0;
      midx_ff <= 2'h0;
      ovf_ff  <= 1'b0;
    end else if (ce) begin
      for (int l = 0; l < `NUM_DLANES; l++) begin
        sh_ff[l]    <= nxt_sh[l];
        lbyte_ff[l] <= nxt_lbyte[l];
        bcnt_ff[l]  <= nxt_bcnt[l];
      end
      algn_ff <= nxt_algn;
      have_ff <= nxt_have;
      mrg_ff  <= nxt_mrg;
      midx_ff <= nxt_midx;
      ovf_ff  <= nxt_ovf;
    end
  end

  // ----------------------------------------------------------------
  // Packet parser
  // ----------------------------------------------------------------
  pkt_st_t     pst_ff, nxt_pst;
  logic [1:0]  pcnt_ff, nxt_pcnt;
  logic [23:0] hdr_ff, nxt_hdr;
  logic [15:0] wc_ff, nxt_wc;
  logic [15:0] crc_ff, nxt_crc;
  logic [7:0]  flo_ff, nxt_flo;
  logic        sval_ff, nxt_sval;
  logic [7:0]  sid_ff, nxt_sid;
  logic [15:0] sdat_ff, nxt_sdat;
  logic        infr_ff, nxt_infr;
  logic        ecor_ff, nxt_ecor;
  logic        eerr_ff, nxt_eerr;
  logic        cerr_ff, nxt_cerr;
  logic        fifo_rdy;
  logic        fifo_wr;
  logic [25:0] fix;

  always_comb begin
    nxt_pst  = pst_ff;
    nxt_pcnt = pcnt_ff;
    nxt_hdr  = hdr_ff;
    nxt_wc   = wc_ff;
    nxt_crc  = crc_ff;
    nxt_flo  = flo_ff;
    nxt_sval = 1'b0;
    nxt_sid  = sid_ff;
    nxt_sdat = sdat_ff;
    nxt_infr = infr_ff;
    nxt_ecor = 1'b0;
    nxt_eerr = err_clr ? 1'b0 : eerr_ff;
    nxt_cerr = err_clr ? 1'b0 : cerr_ff;
    fix      = ecc_fix({mb_data[7:0], hdr_ff[23:8]}, 6'h00);
    // Payload outside a frame is dropped, so it never stalls the merge
    pkt_ready = (pst_ff != PS_PAY) || fifo_rdy || !infr_ff;
    fifo_wr   = mb_valid && burst_on && (pst_ff == PS_PAY) && infr_ff;
    if (!burst_on) begin
      nxt_pst  = PS_HDR;
      nxt_pcnt = 2'h0;
    end else if (mb_valid && pkt_ready) begin
      nxt_pcnt = 2'(pcnt_ff + 2'h1);
      case (pst_ff)
        PS_HDR: begin
          nxt_hdr = {mb_data, hdr_ff[23:8]};
          if (pcnt_ff == `HDR_BYTES) begin
            fix      = ecc_fix(hdr_ff, mb_data[5:0]);
            nxt_pcnt = 2'h0;
            nxt_ecor = fix[24];
            if (fix[25]) begin
              nxt_eerr = 1'b1;
              nxt_pst  = PS_SKIP;
            end else if (fix[5:0] <= `SHORT_DT_MAX) begin
              nxt_sval = 1'b1;
              nxt_sid  = fix[7:0];
              nxt_sdat = fix[23:8];
              if (fix[5:0] == `DT_FRAME_START) nxt_infr = 1'b1;
              if (fix[5:0] == `DT_FRAME_END) nxt_infr = 1'b0;
            end else begin
              nxt_wc  = fix[23:8];
              nxt_crc = `CRC_INIT;
              nxt_pst = (fix[23:8] == 16'h0000) ? PS_FTR : PS_PAY;
            end
          end
        end
        PS_PAY: begin
          nxt_pcnt = 2'h0;
          nxt_crc  = crc_byte(crc_ff, mb_data);
          nxt_wc   = 16'(wc_ff - 16'h0001);
          if (wc_ff == 16'h0001) nxt_pst = PS_FTR;
        end
        PS_FTR: begin
          nxt_flo = mb_data;
          if (pcnt_ff == 2'h1) begin
            nxt_pcnt = 2'h0;
            nxt_pst  = PS_HDR;
            if ({mb_data, flo_ff} != crc_ff) nxt_cerr = 1'b1;
          end
        end
        PS_SKIP: nxt_pcnt = 2'h0;
        default: nxt_pst = PS_HDR;
      endcase
    end
  end

  always_ff @(posedge mclk) begin
    if (srst) begin
      pst_ff  <= PS_HDR;
      pcnt_ff <= 2'h0;
      hdr_ff  <= 24'h000000;
      wc_ff   <= 16'h0000;
      crc_ff  <= `CRC_INIT;
      flo_ff  <= 8'h00;
      sval_ff <= 1'b0;
      sid_ff  <= 8'h00;
      sdat_ff <= 16'h0000;
      infr_ff <= 1'b0;
      ecor_ff <= 1'b0;
      eerr_ff <= 1'b0;
      cerr_ff <= 1'b0;
    end else if (ce) begin
      pst_ff  <= nxt_pst;
      pcnt_ff <= nxt_pcnt;
      hdr_ff  <= nxt_hdr;
      wc_ff   <= nxt_wc;
      crc_ff  <= nxt_crc;
      flo_ff  <= nxt_flo;
      sval_ff <= nxt_sval;
      sid_ff  <= nxt_sid;
      sdat_ff <= nxt_sdat;
      infr_ff <= nxt_infr;
      ecor_ff <= nxt_ecor;
      eerr_ff <= nxt_eerr;
      cerr_ff <= nxt_cerr;
    end
  end

  assign short_valid = sval_ff;
  assign short_id    = sid_ff;
  assign short_data  = sdat_ff;
  assign in_frame    = infr_ff;
  assign ecc_corr    = ecor_ff;
  assign ecc_err     = eerr_ff;
  assign crc_err     = cerr_ff;
  assign ovf_err     = ovf_ff;

  // ----------------------------------------------------------------
  // Payload buffer
  // ----------------------------------------------------------------
  csi2_byte_fifo #(
    .W (`FIFO_WIDTH),
    .D (`FIFO_DEPTH)
  ) u_fifo (
    .mclk      (mclk),
    .srst      (srst),
    .ce        (ce),
    .in_valid  (fifo_wr),
    .in_data   ({(wc_ff == 16'h0001), mb_data}),
    .in_ready  (fifo_rdy),
    .out_valid (pix_valid),
    .out_data  ({pix_last, pix_data}),
    .out_ready (pix_ready)
  );

endmodule

`default_nettype wire

// >>> tb/csi2_rx_monitor.sv
// Concurrent checks on the lane receive front end, bound to its top module.
// Assumes ce stays high, so pin changes reach the lane state in 3 mclk.
`timescale 1ns/1ps
`default_nettype none

module csi2_rx_monitor (
  // Clock, reset, configuration
  input wire logic       mclk,
  input wire logic       srst,
  input wire logic       cfg_cont_clk,
  input wire logic [1:0] cfg_lanes,
  input wire logic       err_clr,
  // Lane pins
  input wire logic       clk_lp_p,
  input wire logic       clk_lp_n,
  input wire logic [3:0] dat_lp_p,
  input wire logic [3:0] dat_lp_n,
  // Observed outputs
  input wire logic       clk_term_en,
  input wire logic [3:0] dat_term_en,
  input wire logic       short_valid,
  input wire logic [7:0] short_id,
  input wire logic       in_frame,
  input wire logic       pix_valid,
  input wire logic [7:0] pix_data,
  input wire logic       pix_last,
  input wire logic       pix_ready,
  input wire logic       ecc_err,
  input wire logic       crc_err
);
  default clocking cb @(posedge mclk); endclocking
  default disable iff (srst);

  chk_entry_bridge: assert property (
    $rose(dat_term_en[0]) |-> $past({dat_lp_p[0], dat_lp_n[0]}, 3) == 2'b00)
    else $error("lane 0 terminated without bridge state");
  chk_hs_hold: assert property (
    dat_term_en[0] && $past({dat_lp_p[0], dat_lp_n[0]}, 2) == 2'b00 |=> dat_term_en[0])
    else $error("lane 0 left high speed before stop");
  chk_stop_exit: assert property (
    $fell(dat_term_en[0]) |-> $past({dat_lp_p[0], dat_lp_n[0]}, 3) == 2'b11)
    else $error("lane 0 left high speed without stop");
  chk_cont_clock: assert property (
    cfg_cont_clk [*4] |-> clk_term_en)
    else $error("clock lane not terminated in continuous mode");
  chk_clk_idle: assert property (
    !cfg_cont_clk && !$past(cfg_cont_clk) && !$past(cfg_cont_clk, 2)
    && $past({clk_lp_p, clk_lp_n}, 3) == 2'b11 |-> !clk_term_en)
    else $error("clock lane terminated in stop state");
  chk_lane_count: assert property (
    cfg_lanes != 2'b10 && $past(cfg_lanes) != 2'b10 |-> dat_term_en[3:2] == 2'b00)
    else $error("inactive lane terminated");
  chk_short_range: assert property (
    short_valid |-> short_id[5:0] <= 6'h0f)
    else $error("short packet with long data type");
  chk_frame_start: assert property (
    $rose(in_frame) |-> short_id[5:0] == 6'h00 && (short_valid || $past(short_valid)))
    else $error("frame opened without frame start");
  chk_pix_stall: assert property (
    pix_valid && !pix_ready |=> pix_valid && $stable(pix_data) && $stable(pix_last))
    else $error("payload byte changed while stalled");
  chk_ecc_sticky: assert property (
    ecc_err && !err_clr |=> ecc_err)
    else $error("header error flag lost");
  chk_crc_sticky: assert property (
    crc_err && !err_clr |=> crc_err)
    else $error("checksum error flag lost");
endmodule

bind csi2_rx_front_end csi2_rx_monitor csi2_rx_monitor_i (.mclk, .srst, .cfg_cont_clk,
  .cfg_lanes, .err_clr, .clk_lp_p, .clk_lp_n, .dat_lp_p, .dat_lp_n, .clk_term_en,
  .dat_term_en, .short_valid, .short_id, .in_frame, .pix_valid, .pix_data, .pix_last,
  .pix_ready, .ecc_err, .crc_err);

`default_nettype wire

// >>> tb/csi2_sensor_model.sv
// Behavioural image sensor driving one clock lane and four data lanes.
// Assumes the receiver oversamples every pin with its own faster clock.
`timescale 1ns/1ps
`default_nettype none

module csi2_sensor_model (
  // Clock lane
  output logic       clk_lp_p,
  output logic       clk_lp_n,
  output logic       clk_hs,
  // Data lanes
  output logic [3:0] dat_lp_p,
  output logic [3:0] dat_lp_n,
  output logic [3:0] dat_hs
);
  logic [3:0] act;
  initial begin
    {clk_lp_p, clk_lp_n, clk_hs} = 3'b110;
    dat_lp_p = 4'hf;
    dat_lp_n = 4'hf;
    dat_hs = 4'h5;
    act = 4'h1;
  end

  // One line state for 100 ns; lanes outside act stay in stop state
  task automatic lp(input logic [1:0] v, input bit ck);
    dat_lp_p = v[1] ? 4'hf : ~act;
    dat_lp_n = v[0] ? 4'hf : ~act;
    if (ck) {clk_lp_p, clk_lp_n} = v;
    #100;
  endtask

  // Lane clock toggles every 100 ns, data changes midway between edges
  task automatic burst(input logic [7:0] q[$], input int nl, input bit cont);
    logic [7:0] b;
    act = 4'((1 << nl) - 1);
    if (cont) {clk_lp_p, clk_lp_n} = 2'b00;
    lp(2'b11, !cont);
    lp(2'b01, !cont);
    lp(2'b00, !cont);
    for (int k = -1; k < q.size() / nl; k++) begin
      for (int i = 0; i < 8; i++) begin
        for (int l = 0; l < nl; l++) begin
          b = (k < 0) ? 8'hb8 : q[k * nl + l];
          dat_hs[l] = b[i];
        end
        #50 clk_hs = ~clk_hs;
        #50;
      end
    end
    // Trail time: the last byte group must leave the merge before stop
    #200;
    lp(2'b11, !cont);
    // Released lines must not keep showing the last bit
    dat_hs = ~dat_hs;
  endtask
endmodule

`default_nettype wire

// >>> tb/csi2_rx_front_end_tb_top.sv
// Self-checking bench: the sensor model bursts packets into the receiver.
// Assumes the checker file is compiled alongside and binds itself.
`timescale 1ns/1ps
`default_nettype none

module csi2_rx_front_end_tb_top;
  logic        mclk, srst, ce, cfg_cont_clk, err_clr, clk_lp_p, clk_lp_n, clk_hs;
  logic [1:0]  cfg_lanes;
  logic [3:0]  dat_lp_p, dat_lp_n, dat_hs, dat_term_en;
  logic        clk_term_en, short_valid, in_frame, pix_valid, pix_last, ecc_corr;
  logic        ecc_err, crc_err, ovf_err, frm;
  logic [7:0]  short_id, pix_data, tx[$];
  logic [15:0] short_data;
  logic [23:0] exp_s[$];
  logic [8:0]  exp_p[$];
  logic        pix_ready = 1'b1;
  logic [31:0] r = 32'h0001_56c8, pr = 32'h0001_56c8;
  int          fail_count, comparisons, ncorr;

  csi2_rx_front_end csi2_rx_front_end_i (.mclk, .srst, .ce, .cfg_cont_clk, .cfg_lanes,
    .err_clr, .clk_lp_p, .clk_lp_n, .clk_hs, .dat_lp_p, .dat_lp_n, .dat_hs, .clk_term_en,
    .dat_term_en, .short_valid, .short_id, .short_data, .in_frame, .pix_valid, .pix_data,
    .pix_last, .pix_ready, .ecc_corr, .ecc_err, .crc_err, .ovf_err);
  csi2_sensor_model csi2_sensor_model_i (.clk_lp_p, .clk_lp_n, .clk_hs, .dat_lp_p,
    .dat_lp_n, .dat_hs);

  function automatic logic [31:0] lfsr_next(input logic [31:0] x);
    return {x[30:0], x[31] ^ x[21] ^ x[1] ^ x[0]};
  endfunction
  function automatic logic [7:0] ecc_of(input logic [23:0] d);
    return {2'b00, ^(d & 24'heffc00), ^(d & 24'hdf03f0), ^(d & 24'hb8e38e),
            ^(d & 24'h749a6d), ^(d & 24'hf2555b), ^(d & 24'hf12cb7)};
  endfunction
  function automatic logic [15:0] crc_step(input logic [15:0] c, input logic [7:0] d);
    for (int i = 0; i < 8; i++)
      c = (c[0] ^ d[i]) ? (c >> 1) ^ 16'h8408 : c >> 1;
    return c;
  endfunction

  task automatic cmp(input string n, input logic [31:0] e, input logic [31:0] s);
    comparisons++;
    if (s !== e) begin
      fail_count++;
      $display("unexpected %s expected %h seen %h", n, e, s);
    end
  endtask

  // Queue one packet for the sensor and its expected results
  task automatic pkt(input logic [7:0] di, input logic [15:0] wc,
                     input logic [31:0] flip, input bit bad);
    logic [31:0] h;
    logic [15:0] c;
    h = {ecc_of({wc, di}), wc, di} ^ flip;
    for (int i = 0; i < 4; i++) tx.push_back(h[8 * i +: 8]);
    if (di[5:0] <= 6'h0f) begin
      if ($countones(flip) < 2) exp_s.push_back({di, wc});
      if (di[5:0] == 6'h00) frm = 1'b1;
      if (di[5:0] == 6'h01) frm = 1'b0;
    end else begin
      c = 16'hffff;
      for (int i = 0; i < wc; i++) begin
        r = lfsr_next(r);
        tx.push_back(r[7:0]);
        c = crc_step(c, r[7:0]);
        if (frm) exp_p.push_back({i == wc - 1, r[7:0]});
      end
      c = c ^ {15'h0000, bad};
      tx.push_back(c[7:0]);
      tx.push_back(c[15:8]);
    end
  endtask

  task automatic frame(input bit bad);
    pkt(8'h00, r[15:0], 32'h0, 1'b0);
    pkt(8'h6a, 16'h0006, 32'h0, bad);
    pkt(8'h10, 16'h0002, 32'h0, 1'b0);
    pkt(8'h0f, r[31:16], 32'h0, 1'b0);
    pkt(8'h01, r[15:0], 32'h0, 1'b0);
  endtask

  task automatic send(input int nl, input bit cont);
    @(posedge mclk);
    #7;
    fork
      csi2_sensor_model_i.burst(tx, nl, cont);
      begin
        #610;
        cmp("dat_term_en in burst", (1 << nl) - 1, dat_term_en);
        cmp("clk_term_en in burst", 1, clk_term_en);
      end
    join
    tx.delete();
    repeat (4) @(posedge mclk);
    for (int i = 0; i < 3000 && exp_p.size() + exp_s.size() > 0; i++) @(posedge mclk);
    cmp("backlog", 0, exp_p.size() + exp_s.size());
    if (exp_p.size() + exp_s.size() > 0) tally_and_finish();
    cmp("dat_term_en after stop", 0, dat_term_en);
  endtask

  task automatic tally_and_finish();
    $display("comparisons %0d fail_count %0d", comparisons, fail_count);
    if (fail_count == 0 && comparisons > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask

  // Results are compared in the cycle they stand; the sink stalls at random
  always @(posedge mclk) begin
    pr <= lfsr_next(pr);
    pix_ready <= pr[3] | pr[9];
    if (!srst) begin
      if (ecc_corr) ncorr++;
      if (short_valid)
        cmp("short", exp_s.size() ? exp_s.pop_front() : 24'hx, {short_id, short_data});
      if (pix_valid && pix_ready)
        cmp("pix", exp_p.size() ? exp_p.pop_front() : 9'hx, {pix_last, pix_data});
    end
  end

  initial begin
    mclk = 1'b0;
    forever #12.5 mclk = ~mclk;
  end

  initial begin
    {srst, ce, cfg_cont_clk, err_clr, frm} = 5'b11000;
    cfg_lanes = 2'b00;
    repeat (2) @(posedge mclk);
    srst <= 1'b0;
    @(posedge mclk);
    cmp("outputs after reset", 0, {clk_term_en, dat_term_en, in_frame, ecc_err, crc_err});
    // Escape entry goes stop, then 10, then bridge: never high speed
    #7;
    csi2_sensor_model_i.lp(2'b10, 1'b1);
    csi2_sensor_model_i.lp(2'b00, 1'b1);
    cmp("term after escape entry", 0, {clk_term_en, dat_term_en});
    csi2_sensor_model_i.lp(2'b11, 1'b1);
    for (int c = 0; c < 3; c++) begin
      @(posedge mclk);
      cfg_lanes <= 2'(c);
      frame(1'b0);
      send(1 << c, 1'b0);
      cmp("flags after frame", 0, {in_frame, crc_err, ecc_err, ovf_err});
    end
    @(posedge mclk);
    cfg_cont_clk <= 1'b1;
    frame(1'b1);
    send(4, 1'b1);
    cmp("clk_term_en continuous", 1, clk_term_en);
    cmp("crc_err on bad checksum", 1, crc_err);
    err_clr <= 1'b1;
    @(posedge mclk);
    err_clr <= 1'b0;
    cfg_cont_clk <= 1'b0;
    @(posedge mclk);
    @(posedge mclk);
    cmp("crc_err after clear", 0, crc_err);
    pkt(8'h02, r[15:0], 32'h0000_0100, 1'b0);
    pkt(8'h03, r[15:0], 32'h0000_0005, 1'b0);
    send(4, 1'b0);
    cmp("ecc corrections", 1, ncorr);
    cmp("ecc_err on double flip", 1, ecc_err);
    tally_and_finish();
  end
endmodule

`default_nettype wire
